//--- logic/uirq_defs.svh
// Offsets, field positions and reset values of the serial port interrupt block
`ifndef UIRQ_DEFS_SVH
`define UIRQ_DEFS_SVH
`define UIRQ_OFF_CTRL   12'h000
`define UIRQ_OFF_IE     12'h004
`define UIRQ_OFF_STAT   12'h008
`define UIRQ_OFF_EVENT  12'h00c
`define UIRQ_OFF_IMASK  12'h010
`define UIRQ_OFF_TXBUF  12'h014
`define UIRQ_OFF_RXBUF  12'h018
// Control register fields
`define UIRQ_CTRL_SWRST   0
`define UIRQ_CTRL_DORM    1
`define UIRQ_CTRL_BRKIE   2
`define UIRQ_CTRL_RXEIE   3
`define UIRQ_CTRL_MODE_LO 4
`define UIRQ_CTRL_MODE_HI 5
`define UIRQ_CTRL_SMSEL   6
`define UIRQ_CTRL_GIE     7
`define UIRQ_CTRL_RESET   8'h01
// Interrupt enable fields
`define UIRQ_IE_RX 0
`define UIRQ_IE_TX 1
// Status fields
`define UIRQ_ST_RX   0
`define UIRQ_ST_TX   1
`define UIRQ_ST_BRK  2
`define UIRQ_ST_CREQ 3
// Sticky event fields
`define UIRQ_EV_RX  0
`define UIRQ_EV_TX  1
`define UIRQ_EV_BRK 2
`define UIRQ_EV_W   3
`endif

//--- logic/uirq_pkg.sv
// Types shared by the serial port interrupt block
package uirq_pkg;
    typedef enum logic [1:0]
    {
        UIRQ_MODE_PLAIN = 2'b00,
        UIRQ_MODE_IDLE  = 2'b01,
        UIRQ_MODE_ADDR  = 2'b10,
        UIRQ_MODE_AUTO  = 2'b11
    } uirq_mode_type;

    typedef struct packed
    {
        logic       done;
        logic       is_error;
        logic       is_addr;
        logic       is_break;
        logic [7:0] data;
    } uirq_rx_type;

    typedef struct packed
    {
        logic tx_shifting;
        logic rx_active;
        logic tx_pending;
    } uirq_busy_type;

    typedef enum logic [1:0]
    {
        UIRQ_CLK_IDLE  = 2'b00,
        UIRQ_CLK_FORCE = 2'b01,
        UIRQ_CLK_DRAIN = 2'b11
    } uirq_clk_type;
endpackage

//--- logic/uirq_top.sv
// Interrupt flags, APB registers and clock request of one serial port
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "uirq_defs.svh"

// Summary of operation
// - Force sub-main clock on when selected, stopped and needed by the port.
// - Hold forced request until idle, then clock-source bits rule again.
// - Never request the auxiliary clock automatically.
// - Forced clock drives a device-wide clock-on output.
// - Three request outputs: one transmit, one receive, one summary of the masked sticky events.
// - Transmit flag set when buffer free; request needs enable and global.
// - Writing the transmit buffer clears the transmit flag.
// - Power-up clear or soft reset sets tx flag, clears tx enable.
// - Rx flag set per loaded character; request needs enable and global.
// - Power-up clear or soft reset clears rx flag and rx enable.
// - Reading the receive buffer clears the receive flag.
// - With error enable off, erroneous characters do not set rx flag.
// - Dormant: only address chars in multiprocessor modes, none in plain.
// - Break enable set: break sets break status and receive flag.
// - Rx flags of both ports merge to one request, tx flags to another.
module uirq_top
    import uirq_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire uirq_rx_type   rx_char,
    input  wire logic          tx_buffer_free,
    input  wire uirq_busy_type busy,
    input  wire logic          sub_main_clock_stopped,
    input  wire logic          companion_rx_flag,
    input  wire logic          companion_tx_flag,
    output logic      [7:0]    tx_buffer,
    output logic               tx_load,
    output logic               rx_irq,
    output logic               tx_irq,
    output logic               sub_main_clock_force,
    output logic               irq
);

    logic [7:0]              ctrl_q;
    logic [1:0]              ie_q;
    logic                    rx_flag_q;
    logic                    tx_flag_q;
    logic                    brk_q;
    logic [7:0]              rx_buffer_q;
    logic [`UIRQ_EV_W-1:0]   event_q;
    logic [`UIRQ_EV_W-1:0]   imask_q;
    uirq_clk_type            clk_state_q;
    logic                    wr_en;
    logic                    rd_en;
    logic                    swrst;
    logic                    rx_ok;
    logic                    brk_set;
    logic                    rx_set;
    logic                    tx_set;
    logic                    port_busy;
    logic                    global_irq_enable;
    logic                    rx_flag_clr;
    logic                    tx_flag_clr;
    uirq_mode_type           mode;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Zero wait states: every access completes in its first access cycle
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign swrst = ctrl_q[`UIRQ_CTRL_SWRST];
    assign global_irq_enable = ctrl_q[`UIRQ_CTRL_GIE];
    assign mode = uirq_mode_type'(ctrl_q[`UIRQ_CTRL_MODE_HI:`UIRQ_CTRL_MODE_LO]);

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ctrl_q <= `UIRQ_CTRL_RESET;
        end
        else if (wr_en && paddr == `UIRQ_OFF_CTRL)
        begin
            ctrl_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ie_q <= 2'h0;
        end
        else if (swrst)
        begin
            ie_q <= 2'h0;
        end
        else if (wr_en && paddr == `UIRQ_OFF_IE)
        begin
            ie_q <= pwdata[1:0];
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            imask_q <= '0;
        end
        else if (wr_en && paddr == `UIRQ_OFF_IMASK)
        begin
            imask_q <= pwdata[`UIRQ_EV_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Receive filtering
    // ------------------------------------------------------------
    always_comb
    begin
        rx_ok = rx_char.done && !rx_char.is_break;
        if (rx_char.is_error && !ctrl_q[`UIRQ_CTRL_RXEIE])
        begin
            rx_ok = 1'b0;
        end
        if (ctrl_q[`UIRQ_CTRL_DORM])
        begin
            if (mode == UIRQ_MODE_PLAIN || !rx_char.is_addr)
            begin
                rx_ok = 1'b0;
            end
        end
    end

    assign brk_set = rx_char.done && rx_char.is_break
                     && ctrl_q[`UIRQ_CTRL_BRKIE] && !swrst;
    assign rx_set = (rx_ok || brk_set) && !swrst;
    assign tx_set = tx_buffer_free && !tx_load;
    assign rx_flag_clr = rd_en && paddr == `UIRQ_OFF_RXBUF;
    assign tx_flag_clr = wr_en && paddr == `UIRQ_OFF_TXBUF;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rx_buffer_q <= 8'h00;
        end
        else if (rx_ok && !swrst)
        begin
            rx_buffer_q <= rx_char.data;
        end
    end

    // ------------------------------------------------------------
    // Interrupt flags
    // ------------------------------------------------------------
    // A new character in the same cycle as the read keeps the flag set
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rx_flag_q <= 1'b0;
        end
        else if (swrst)
        begin
            rx_flag_q <= 1'b0;
        end
        else if (rx_set)
        begin
            rx_flag_q <= 1'b1;
        end
        else if (rx_flag_clr)
        begin
            rx_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            tx_flag_q <= 1'b1;
        end
        else if (swrst)
        begin
            tx_flag_q <= 1'b1;
        end
        else if (tx_flag_clr)
        begin
            tx_flag_q <= 1'b0;
        end
        else if (tx_set)
        begin
            tx_flag_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            brk_q <= 1'b0;
        end
        else if (swrst)
        begin
            brk_q <= 1'b0;
        end
        else if (brk_set)
        begin
            brk_q <= 1'b1;
        end
        else if (rx_flag_clr)
        begin
            brk_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            tx_buffer <= 8'h00;
            tx_load   <= 1'b0;
        end
        else
        begin
            tx_load <= tx_flag_clr && !swrst;
            if (tx_flag_clr && !swrst)
            begin
                tx_buffer <= pwdata[7:0];
            end
        end
    end

    // Two request outputs, each shared with the companion port
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rx_irq <= 1'b0;
            tx_irq <= 1'b0;
        end
        else
        begin
            rx_irq <= (rx_flag_q && ie_q[`UIRQ_IE_RX] && global_irq_enable)
                      || companion_rx_flag;
            tx_irq <= (tx_flag_q && ie_q[`UIRQ_IE_TX] && global_irq_enable)
                      || companion_tx_flag;
        end
    end

    // ------------------------------------------------------------
    // Sticky events for the summary interrupt
    // ------------------------------------------------------------
    genvar gi;
    logic [`UIRQ_EV_W-1:0] ev_set;
    assign ev_set[`UIRQ_EV_RX]  = rx_set;
    assign ev_set[`UIRQ_EV_TX]  = tx_set && !tx_flag_q && !swrst;
    assign ev_set[`UIRQ_EV_BRK] = brk_set;
    generate
        for (gi = 0; gi < `UIRQ_EV_W; gi = gi + 1)
        begin : g_ev
            always_ff @(posedge clk or posedge reset)
            begin
                if (reset)
                begin
                    event_q[gi] <= 1'b0;
                end
                else if (ev_set[gi])
                begin
                    event_q[gi] <= 1'b1;
                end
                else if (wr_en && paddr == `UIRQ_OFF_EVENT && pwdata[gi])
                begin
                    event_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(event_q & imask_q);
        end
    end

    // ------------------------------------------------------------
    // Clock request
    // ------------------------------------------------------------
    // Only the sub-main clock can be forced; the auxiliary source gets
    // no request at all, so a stopped auxiliary clock stalls the port.
    assign port_busy = busy.tx_shifting || busy.rx_active
                       || busy.tx_pending;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            clk_state_q <= UIRQ_CLK_IDLE;
        end
        else
        begin
            case (clk_state_q)
                UIRQ_CLK_IDLE:
                begin
                    if (port_busy && ctrl_q[`UIRQ_CTRL_SMSEL]
                        && sub_main_clock_stopped)
                    begin
                        clk_state_q <= UIRQ_CLK_FORCE;
                    end
                end
                UIRQ_CLK_FORCE:
                begin
                    if (!port_busy)
                    begin
                        clk_state_q <= UIRQ_CLK_DRAIN;
                    end
                end
                UIRQ_CLK_DRAIN:
                begin
                    if (port_busy)
                    begin
                        clk_state_q <= UIRQ_CLK_FORCE;
                    end
                    else
                    begin
                        clk_state_q <= UIRQ_CLK_IDLE;
                    end
                end
                default:
                begin
                    clk_state_q <= UIRQ_CLK_IDLE;
                end
            endcase
        end
    end

    // Output is device-wide: other users of the clock see it run too
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sub_main_clock_force <= 1'b0;
        end
        else
        begin
            sub_main_clock_force <= (clk_state_q == UIRQ_CLK_FORCE);
        end
    end

    // ------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
            if (psel && !penable && !pwrite)
            begin
                case (paddr)
                    `UIRQ_OFF_CTRL:  prdata <= {24'h0, ctrl_q};
                    `UIRQ_OFF_IE:    prdata <= {30'h0, ie_q};
                    `UIRQ_OFF_STAT:  prdata <= {28'h0,
                        clk_state_q == UIRQ_CLK_FORCE, brk_q,
                        tx_flag_q, rx_flag_q};
                    `UIRQ_OFF_EVENT: prdata <= {29'h0, event_q};
                    `UIRQ_OFF_IMASK: prdata <= {29'h0, imask_q};
                    `UIRQ_OFF_TXBUF: prdata <= {24'h0, tx_buffer};
                    `UIRQ_OFF_RXBUF: prdata <= {24'h0, rx_buffer_q};
                    default:         prdata <= 32'h0;
                endcase
            end
            if (psel && !penable && paddr > `UIRQ_OFF_RXBUF)
            begin
                pslverr <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_txclr;
        @(posedge clk) disable iff (reset)
        (wr_en && paddr == `UIRQ_OFF_TXBUF && !swrst) |=> !tx_flag_q;
    endproperty
    a_txclr: assert property (p_txclr) else $error("tx flag kept");

    property p_rxclr;
        @(posedge clk) disable iff (reset)
        (rx_flag_clr && !rx_set) |=> !rx_flag_q;
    endproperty
    a_rxclr: assert property (p_rxclr) else $error("rx flag kept");

    property p_swrst;
        @(posedge clk) disable iff (reset)
        swrst |=> (tx_flag_q && !rx_flag_q && ie_q == 2'h0);
    endproperty
    a_swrst: assert property (p_swrst) else $error("bad reset");

    property p_err;
        @(posedge clk) disable iff (reset)
        (rx_char.done && rx_char.is_error && !rx_char.is_break
         && !ctrl_q[`UIRQ_CTRL_RXEIE] && !rx_flag_q) |=> !rx_flag_q;
    endproperty
    a_err: assert property (p_err) else $error("error char flagged");

    property p_dorm;
        @(posedge clk) disable iff (reset)
        (rx_char.done && !rx_char.is_break && ctrl_q[`UIRQ_CTRL_DORM]
         && mode == UIRQ_MODE_PLAIN && !rx_flag_q) |=> !rx_flag_q;
    endproperty
    a_dorm: assert property (p_dorm) else $error("dormant flagged");

    property p_brk;
        @(posedge clk) disable iff (reset)
        (brk_set && !swrst) |=> (brk_q && rx_flag_q);
    endproperty
    a_brk: assert property (p_brk) else $error("break not flagged");

    property p_rxirq;
        @(posedge clk) disable iff (reset)
        (rx_flag_q && ie_q[`UIRQ_IE_RX] && global_irq_enable) |=> rx_irq;
    endproperty
    a_rxirq: assert property (p_rxirq) else $error("no rx irq");

    property p_txirq;
        @(posedge clk) disable iff (reset)
        (!global_irq_enable && !companion_tx_flag) |=> !tx_irq;
    endproperty
    a_txirq: assert property (p_txirq) else $error("tx irq no gie");

    property p_force;
        @(posedge clk) disable iff (reset)
        (clk_state_q == UIRQ_CLK_FORCE && port_busy) |=>
            sub_main_clock_force;
    endproperty
    a_force: assert property (p_force) else $error("force off");

    property p_aux;
        @(posedge clk) disable iff (reset)
        (clk_state_q == UIRQ_CLK_IDLE && !ctrl_q[`UIRQ_CTRL_SMSEL])
            |=> clk_state_q == UIRQ_CLK_IDLE;
    endproperty
    a_aux: assert property (p_aux) else $error("aux clock requested");

endmodule
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench of the serial port interrupt block
`timescale 1ns/1ns
`default_nettype none
`include "uirq_defs.svh"
module tb
    import uirq_pkg::*;
;
    localparam int TX_CYC = 12;
    localparam int RX_CYC = 10;
    logic          clk, reset, psel, penable, pwrite, pready, pslverr, se;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, rd;
    uirq_rx_type   rx_char;
    uirq_busy_type busy;
    logic          tx_buffer_free, tx_load, rx_irq, tx_irq, irq;
    logic          sub_main_clock_stopped, sub_main_clock_force;
    logic          companion_rx_flag, companion_tx_flag;
    logic [7:0]    tx_buffer, load_d, rx_data;
    logic          tx_stall, rx_go, fseen;
    logic [2:0]    rx_kind;
    int            err_count, n_tests, cyc, load_n;

    // ----------------------------------------
    // Harness
    // ----------------------------------------
    uirq_top uirq_top_i (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_char(rx_char), .tx_buffer_free(tx_buffer_free), .busy(busy),
        .sub_main_clock_stopped(sub_main_clock_stopped),
        .companion_rx_flag(companion_rx_flag),
        .companion_tx_flag(companion_tx_flag), .tx_buffer(tx_buffer),
        .tx_load(tx_load), .rx_irq(rx_irq), .tx_irq(tx_irq),
        .sub_main_clock_force(sub_main_clock_force), .irq(irq));

    uirq_peer #(.TX_CYC(TX_CYC), .RX_CYC(RX_CYC)) uirq_peer_i (.clk(clk),
        .reset(reset), .tx_load(tx_load), .tx_stall(tx_stall),
        .rx_go(rx_go), .rx_kind(rx_kind), .rx_data(rx_data),
        .rx_char(rx_char), .tx_buffer_free(tx_buffer_free), .busy(busy));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Counting pulses instead of timing them tolerates any load latency within the four-cycle wait of t_tx
    always @(posedge clk)
    begin
        cyc++;
        if (tx_load === 1'b1)
        begin
            load_n++;
            load_d = tx_buffer;
        end
        if (cyc == 20000)
        begin
            err_count++;
            report_and_stop;
        end
    end

    task report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
        n_tests++;
        if (seen !== e)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, seen);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk("pready wait", n, 1);
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
             input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, rd & m, e);
    endtask

    task st(input int b, input logic e, input string nm);
        apb(1'b0, `UIRQ_OFF_STAT, 32'h0);
        chk(nm, rd[b], e);
    endtask

    task send(input logic [2:0] k, input logic [7:0] d);
        fseen = 1'b0;
        @(posedge clk);
        rx_go   <= 1'b1;
        rx_kind <= k;
        rx_data <= d;
        @(posedge clk);
        rx_go <= 1'b0;
        repeat (RX_CYC + 4)
        begin
            @(posedge clk);
            fseen = fseen | sub_main_clock_force;
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        rdc(`UIRQ_OFF_CTRL, 32'hff, 32'h01, "ctrl reset");
        st(`UIRQ_ST_TX, 1'b1, "tx_flag reset");
        st(`UIRQ_ST_RX, 1'b0, "rx_flag reset");
        wr(`UIRQ_OFF_IE, 32'h3);
        rdc(`UIRQ_OFF_IE, 32'h3, 32'h0, "ie in soft reset");
        chk("outputs", {tx_irq, rx_irq, sub_main_clock_force}, 0);
        apb(1'b0, 12'h01c, 32'h0);
        chk("slverr", se, 1'b1);
        chk("unmapped read", rd, 32'h0);
        wr(`UIRQ_OFF_CTRL, 32'h80);
        $display("reset test done");
    endtask

    task t_tx;
        int n0;
        wr(`UIRQ_OFF_IE, 32'h2);
        repeat (4) @(posedge clk);
        chk("tx_irq on", tx_irq, 1'b1);
        wr(`UIRQ_OFF_CTRL, 32'h00);
        repeat (4) @(posedge clk);
        chk("tx_irq no gie", tx_irq, 1'b0);
        wr(`UIRQ_OFF_CTRL, 32'h80);
        tx_stall <= 1'b1;
        n0 = load_n;
        wr(`UIRQ_OFF_TXBUF, 32'ha5);
        repeat (4) @(posedge clk);
        chk("tx loads", load_n - n0, 1);
        chk("tx_buffer", load_d, 8'ha5);
        st(`UIRQ_ST_TX, 1'b0, "tx_flag after write");
        chk("tx_irq after write", tx_irq, 1'b0);
        wr(`UIRQ_OFF_CTRL, 32'h81);
        st(`UIRQ_ST_TX, 1'b1, "tx_flag soft reset");
        rdc(`UIRQ_OFF_IE, 32'h3, 32'h0, "ie soft reset");
        wr(`UIRQ_OFF_CTRL, 32'h80);
        tx_stall <= 1'b0;
        repeat (TX_CYC + 6) @(posedge clk);
        $display("transmit test done");
    endtask

    task t_rx;
        // Control byte, char kind {error, address, break}, flag expected
        logic [7:0] c [10] = '{8'h80, 8'h80, 8'h88, 8'h82, 8'ha2, 8'ha2,
                               8'h92, 8'h84, 8'h80, 8'hb0};
        logic [2:0] k [10] = '{3'h0, 3'h4, 3'h4, 3'h2, 3'h2, 3'h0,
                               3'h2, 3'h1, 3'h1, 3'h0};
        logic       e [10] = '{1, 0, 1, 0, 1, 0, 1, 1, 0, 1};
        wr(`UIRQ_OFF_IE, 32'h1);
        for (int i = 0; i < 10; i++)
        begin
            wr(`UIRQ_OFF_CTRL, c[i]);
            send(k[i], 8'h30 + i[7:0]);
            chk("rx_irq", rx_irq, e[i]);
            st(`UIRQ_ST_RX, e[i], "rx_flag");
            if (i == 7)
                st(`UIRQ_ST_BRK, 1'b1, "break status");
            apb(1'b0, `UIRQ_OFF_RXBUF, 32'h0);
            if (e[i] && i != 7)
                chk("rx data", rd[7:0], 8'h30 + i[7:0]);
            st(`UIRQ_ST_RX, 1'b0, "rx_flag after read");
        end
        wr(`UIRQ_OFF_CTRL, 32'h80);
        send(3'h0, 8'h5a);
        wr(`UIRQ_OFF_CTRL, 32'h81);
        st(`UIRQ_ST_RX, 1'b0, "rx_flag soft reset");
        rdc(`UIRQ_OFF_IE, 32'h3, 32'h0, "ie soft reset");
        wr(`UIRQ_OFF_CTRL, 32'h80);
        $display("receive test done");
    endtask

    task t_irq;
        wr(`UIRQ_OFF_EVENT, 32'h7);
        wr(`UIRQ_OFF_IMASK, 32'h1);
        send(3'h0, 8'h55);
        chk("irq raised", irq, 1'b1);
        rdc(`UIRQ_OFF_EVENT, 32'h1, 32'h1, "rx event");
        wr(`UIRQ_OFF_IMASK, 32'h0);
        repeat (3) @(posedge clk);
        chk("irq masked", irq, 1'b0);
        wr(`UIRQ_OFF_IMASK, 32'h1);
        repeat (3) @(posedge clk);
        chk("irq unmasked", irq, 1'b1);
        wr(`UIRQ_OFF_EVENT, 32'h1);
        repeat (3) @(posedge clk);
        chk("irq cleared", irq, 1'b0);
        apb(1'b0, `UIRQ_OFF_RXBUF, 32'h0);
        $display("event test done");
    endtask

    task t_comp;
        companion_rx_flag <= 1'b1;
        repeat (3) @(posedge clk);
        chk("shared rx", {rx_irq, tx_irq}, 2'b10);
        companion_rx_flag <= 1'b0;
        companion_tx_flag <= 1'b1;
        repeat (3) @(posedge clk);
        chk("shared tx", {rx_irq, tx_irq}, 2'b01);
        companion_tx_flag <= 1'b0;
        repeat (3) @(posedge clk);
        chk("shared off", {rx_irq, tx_irq}, 2'b00);
        $display("shared request test done");
    endtask

    task t_clk;
        wr(`UIRQ_OFF_CTRL, 32'hc0);
        sub_main_clock_stopped <= 1'b1;
        tx_stall <= 1'b1;
        wr(`UIRQ_OFF_TXBUF, 32'h11);
        repeat (6) @(posedge clk);
        chk("force on", sub_main_clock_force, 1'b1);
        st(`UIRQ_ST_CREQ, 1'b1, "forced status");
        repeat (10) @(posedge clk);
        chk("force pending", sub_main_clock_force, 1'b1);
        tx_stall <= 1'b0;
        repeat (TX_CYC / 2) @(posedge clk);
        chk("force shifting", sub_main_clock_force, 1'b1);
        repeat (TX_CYC + 4) @(posedge clk);
        chk("force idle", sub_main_clock_force, 1'b0);
        wr(`UIRQ_OFF_CTRL, 32'h80);
        send(3'h0, 8'h22);
        chk("no aux force", fseen, 1'b0);
        sub_main_clock_stopped <= 1'b0;
        wr(`UIRQ_OFF_CTRL, 32'hc0);
        send(3'h0, 8'h23);
        chk("running clock", fseen, 1'b0);
        $display("clock request test done");
    endtask

    initial
    begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        sub_main_clock_stopped = 1'b0;
        companion_rx_flag = 1'b0;
        companion_tx_flag = 1'b0;
        tx_stall = 1'b0;
        rx_go = 1'b0;
        rx_kind = 3'h0;
        rx_data = 8'h00;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        t_reset;
        t_tx;
        t_rx;
        t_irq;
        t_comp;
        t_clk;
        report_and_stop;
    end
endmodule
`default_nettype wire

//--- sim/uirq_peer.sv
// Behavioural serial peer: transmitter and receiver beside the port
`timescale 1ns/1ns
`default_nettype none
module uirq_peer
    import uirq_pkg::*;
#(
    parameter int TX_CYC = 12,
    parameter int RX_CYC = 10
)
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       tx_load,
    input  wire logic       tx_stall,
    input  wire logic       rx_go,
    input  wire logic [2:0] rx_kind,
    input  wire logic [7:0] rx_data,
    output uirq_rx_type     rx_char,
    output logic            tx_buffer_free,
    output uirq_busy_type   busy
);
    logic       pend_q;
    logic       done_q;
    logic [7:0] shift_q;
    logic [7:0] rcnt_q;
    logic [2:0] kind_q;
    logic [7:0] data_q;

    // Stall keeps the buffer occupied, so the flag cannot refill early
    assign tx_buffer_free = !(pend_q || tx_stall);
    assign busy = '{tx_shifting: shift_q != 8'h00,
                    rx_active: rcnt_q != 8'h00, tx_pending: pend_q};
    // Outside the done pulse the data lines never show the last char
    assign rx_char = '{done: done_q, is_error: done_q & kind_q[2],
                       is_addr: done_q & kind_q[1],
                       is_break: done_q & kind_q[0],
                       data: done_q ? data_q : ~data_q};

    always_ff @(posedge clk or posedge reset)
        if (reset)
        begin
            pend_q  <= 1'b0;
            shift_q <= 8'h00;
        end
        else if (tx_load)
            pend_q <= 1'b1;
        else if (pend_q && !tx_stall)
        begin
            pend_q  <= 1'b0;
            shift_q <= TX_CYC[7:0];
        end
        else if (shift_q != 8'h00)
            shift_q <= shift_q - 8'h01;

    always_ff @(posedge clk or posedge reset)
        if (reset)
        begin
            rcnt_q <= 8'h00;
            done_q <= 1'b0;
            kind_q <= 3'h0;
            data_q <= 8'h00;
        end
        else
        begin
            done_q <= (rcnt_q == 8'h01);
            if (rx_go)
            begin
                rcnt_q <= RX_CYC[7:0];
                kind_q <= rx_kind;
                data_q <= rx_data;
            end
            else if (rcnt_q != 8'h00)
                rcnt_q <= rcnt_q - 8'h01;
        end
endmodule
`default_nettype wire
